// >>> pdr_user_end.sv
// user control end: AXI4-Lite registers driving phase steps, reference select and settings rewrites
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
module pdr_user_end #(
    parameter int         RELOCK_CYC = pdr_pkg::RELOCK_CYC,
    parameter logic [1:0] FB_OUTPUT  = pdr_pkg::FB_OUTPUT
) (
    // clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    // AXI4-Lite write channels
    input  wire logic [7:0]  I_AWADDR,
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    output logic [1:0]       O_BRESP,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    // AXI4-Lite read channels
    input  wire logic [7:0]  I_ARADDR,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    output logic             O_RVALID,
    input  wire logic        I_RREADY,
    // interrupt
    output logic             O_IRQ,
    // link to the loop
    pdr_link_if.user_end     LINK
);
    localparam int HW = $clog2(pdr_pkg::STEP_HOLD_CYC + 1);

    if (pdr_pkg::STEP_HOLD_CYC < 1) begin : g_bad_hold
        $error("pdr_user_end: STEP_HOLD_CYC must be at least 1");
    end

    // true for the offsets this block answers
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == pdr_pkg::OFF_CTRL) || (a == pdr_pkg::OFF_STEP) || (a == pdr_pkg::OFF_SET)
               || (a == pdr_pkg::OFF_STATUS) || (a == pdr_pkg::OFF_IRQ_STAT) || (a == pdr_pkg::OFF_IRQ_MASK);
    endfunction : reg_hit

    // byte-lane merge of write data into an old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = s[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction : merge

    logic [7:0]                 aw_addr_q;
    logic                       aw_got_q;
    logic [31:0]                w_data_q;
    logic [3:0]                 w_strb_q;
    logic                       w_got_q;
    logic                       bvalid_q;
    logic [1:0]                 bresp_q;
    logic                       rvalid_q;
    logic [1:0]                 rresp_q;
    logic [31:0]                rdata_q;
    logic                       wr_do;
    logic [31:0]                wr_val;
    logic [31:0]                rd_val;
    logic [3:0]                 ctrl_q;
    logic [3:0]                 irq_stat_q;
    logic [3:0]                 irq_mask_q;
    logic [3:0]                 irq_set;
    pdr_pkg::pdr_step_state_type step_q;
    logic [HW-1:0]              hold_q;
    logic [1:0]                 sel_q;
    logic                       dir_q;
    logic                       pulse_q;
    logic                       ref_q;
    logic                       step_go;
    logic                       step_done;
    logic                       wb_busy_q;
    logic                       wb_we_q;
    logic [7:0]                 wb_adr_q;
    logic [7:0]                 wb_dat_q;
    logic [7:0]                 wb_rd_q;
    logic                       wb_go;
    logic                       wb_done;
    logic                       wait_start;
    logic                       wait_busy;
    logic                       lock_last_q;
    logic                       stable_last_q;
    logic                       stable;

    // write address and data taken in either order, answered once both are held
    assign O_AWREADY = !aw_got_q && !bvalid_q;
    assign O_WREADY  = !w_got_q && !bvalid_q;
    assign wr_do     = aw_got_q && w_got_q && !bvalid_q;
    assign wr_val    = merge(32'h0000_0000, w_data_q, w_strb_q);

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            aw_got_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_got_q   <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= pdr_pkg::RESP_OKAY;
        end else begin
            if (I_AWVALID && O_AWREADY) begin
                aw_got_q  <= 1'b1;
                aw_addr_q <= I_AWADDR;
            end
            if (I_WVALID && O_WREADY) begin
                w_got_q  <= 1'b1;
                w_data_q <= I_WDATA;
                w_strb_q <= I_WSTRB;
            end
            if (wr_do) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= reg_hit(aw_addr_q) ? pdr_pkg::RESP_OKAY : pdr_pkg::RESP_SLVERR;
            end else if (bvalid_q && I_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign O_BVALID = bvalid_q;
    assign O_BRESP  = bresp_q;

    // read mux of the register file
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (I_ARADDR)
            pdr_pkg::OFF_CTRL:     rd_val[3:0] = ctrl_q;
            pdr_pkg::OFF_SET: begin
                rd_val[7:0]                  = wb_rd_q;
                rd_val[pdr_pkg::SET_BUSY_BIT] = wb_busy_q;
            end
            pdr_pkg::OFF_STATUS: begin
                rd_val[pdr_pkg::STAT_LOCK_BIT] = LINK.lock;
                rd_val[pdr_pkg::STAT_STBL_BIT] = stable;
                rd_val[pdr_pkg::STAT_WB_BIT]   = wb_busy_q;
                rd_val[pdr_pkg::STAT_STEP_BIT] = (step_q != pdr_pkg::ST_IDLE);
            end
            pdr_pkg::OFF_IRQ_STAT: rd_val[3:0] = irq_stat_q;
            pdr_pkg::OFF_IRQ_MASK: rd_val[3:0] = irq_mask_q;
            default:               rd_val      = 32'h0000_0000;
        endcase
    end

    // read answer one cycle after the address is taken
    assign O_ARREADY = !rvalid_q;
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            rvalid_q <= 1'b0;
            rresp_q  <= pdr_pkg::RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else if (I_ARVALID && O_ARREADY) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= reg_hit(I_ARADDR) ? pdr_pkg::RESP_OKAY : pdr_pkg::RESP_SLVERR;
        end else if (rvalid_q && I_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end
    assign O_RVALID = rvalid_q;
    assign O_RDATA  = rdata_q;
    assign O_RRESP  = rresp_q;

    // control and mask registers
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ctrl_q     <= pdr_pkg::CTRL_INIT;
            irq_mask_q <= pdr_pkg::IRQ_INIT;
        end else if (wr_do) begin
            if (aw_addr_q == pdr_pkg::OFF_CTRL) begin
                ctrl_q <= 4'(merge({28'h0000000, ctrl_q}, w_data_q, w_strb_q));
            end
            if (aw_addr_q == pdr_pkg::OFF_IRQ_MASK) begin
                irq_mask_q <= 4'(merge({28'h0000000, irq_mask_q}, w_data_q, w_strb_q));
            end
        end
    end

    // reference switch follows its control bit
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= ctrl_q[pdr_pkg::CTRL_REF_BIT];
        end
    end

    // phase step sequence: set select and direction, toggle, then hold them
    assign step_go   = wr_do && aw_addr_q == pdr_pkg::OFF_STEP && wr_val[pdr_pkg::STEP_GO_BIT]
                     && step_q == pdr_pkg::ST_IDLE;
    assign step_done = (step_q == pdr_pkg::ST_HOLD) && (hold_q == '0);

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            step_q  <= pdr_pkg::ST_IDLE;
            hold_q  <= '0;
            sel_q   <= 2'h0;
            dir_q   <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            unique case (step_q)
                pdr_pkg::ST_IDLE: begin
                    if (step_go) begin
                        step_q <= pdr_pkg::ST_SETUP;
                    end
                end
                pdr_pkg::ST_SETUP: begin
                    sel_q  <= ctrl_q[pdr_pkg::CTRL_SEL_LSB +: 2];
                    dir_q  <= ctrl_q[pdr_pkg::CTRL_DIR_BIT];
                    step_q <= pdr_pkg::ST_TOGGLE;
                end
                pdr_pkg::ST_TOGGLE: begin
                    pulse_q <= !pulse_q;
                    hold_q  <= HW'(pdr_pkg::STEP_HOLD_CYC - 1);
                    step_q  <= pdr_pkg::ST_HOLD;
                end
                pdr_pkg::ST_HOLD: begin
                    if (hold_q == '0) begin
                        step_q <= pdr_pkg::ST_IDLE;
                    end else begin
                        hold_q <= hold_q - HW'(1);
                    end
                end
            endcase
        end
    end

    // settings bus master: one cycle at a time, ended by acknowledge
    assign wb_go   = wr_do && aw_addr_q == pdr_pkg::OFF_SET && !wb_busy_q;
    assign wb_done = wb_busy_q && LINK.wb_ack;

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            wb_busy_q <= 1'b0;
            wb_we_q   <= 1'b0;
            wb_adr_q  <= 8'h00;
            wb_dat_q  <= 8'h00;
            wb_rd_q   <= 8'h00;
        end else if (wb_go) begin
            wb_busy_q <= 1'b1;
            wb_we_q   <= wr_val[pdr_pkg::SET_WE_BIT];
            wb_adr_q  <= wr_val[pdr_pkg::SET_ADR_LSB +: 8];
            wb_dat_q  <= wr_val[pdr_pkg::SET_DAT_LSB +: 8];
        end else if (wb_done) begin
            wb_busy_q <= 1'b0;
            wb_rd_q   <= LINK.wb_dat_r;
        end
    end

    // link drive
    assign LINK.phase_output_select    = sel_q;
    assign LINK.phase_step_direction   = dir_q;
    assign LINK.phase_step_pulse       = pulse_q;
    assign LINK.reference_clock_switch = ref_q;
    assign LINK.wb_cyc                 = wb_busy_q;
    assign LINK.wb_stb                 = wb_busy_q;
    assign LINK.wb_we                  = wb_we_q;
    assign LINK.wb_adr                 = wb_adr_q;
    assign LINK.wb_dat_w               = wb_dat_q;

    // outputs count as stable only after the relock time since the last disturbance
    assign wait_start = (step_q == pdr_pkg::ST_TOGGLE && sel_q == FB_OUTPUT)
                      || (wb_done && wb_we_q)
                      || (ref_q != ctrl_q[pdr_pkg::CTRL_REF_BIT]);

    pdr_relock #(.CYC(RELOCK_CYC)) pdr_relock_inst (
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_start (wait_start),
        .o_busy  (wait_busy)
    );
    assign stable = LINK.lock && !wait_busy;

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            lock_last_q   <= 1'b0;
            stable_last_q <= 1'b0;
        end else begin
            lock_last_q   <= LINK.lock;
            stable_last_q <= stable;
        end
    end

    // sticky events, cleared by writing one; a new event wins over its clear
    always_comb begin
        irq_set                        = 4'h0;
        irq_set[pdr_pkg::IRQ_STEP_BIT] = step_done;
        irq_set[pdr_pkg::IRQ_SET_BIT]  = wb_done;
        irq_set[pdr_pkg::IRQ_LOST_BIT] = lock_last_q && !LINK.lock;
        irq_set[pdr_pkg::IRQ_STBL_BIT] = stable && !stable_last_q;
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            irq_stat_q <= pdr_pkg::IRQ_INIT;
        end else if (wr_do && aw_addr_q == pdr_pkg::OFF_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~wr_val[3:0]) | irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end
    assign O_IRQ = |(irq_stat_q & irq_mask_q);
endmodule : pdr_user_end

// >>> pdr_pkg.sv
// constants, fields and state types shared by both ends of the loop control link
// Overview of operation
// - each output phase fixed or stepped at run time
// - feedback-output step may drop lock; wait relock time
// - user selects between two reference clock sources
// - user rewrites loop settings over a bus port
// - user side provides the bus bridge master
// - settings rewrite may drop lock; wait relock time
// - two-bit select picks output, driven before step
// - direction held stable while a step issues
// - each step toggle moves phase one increment
package pdr_pkg;
    // loop geometry
    localparam int          NUM_OUT        = 4;
    localparam int          SEL_W          = 2;
    localparam int          PHASE_W        = 3;
    localparam logic [2:0]  PHASE_INIT     = 3'h0;
    localparam logic [3:0]  DYN_MASK       = 4'hF;  // outputs that accept run-time steps
    localparam logic [1:0]  FB_OUTPUT      = 2'h0;  // output used as feedback source
    // settings bus port
    localparam int          WB_AW          = 8;
    localparam int          WB_DW          = 8;
    localparam int          NUM_SET        = 4;
    localparam logic [7:0]  SET_INIT       = 8'h01;
    // timing
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          RELOCK_TIME_NS = 1000;
    localparam int          RELOCK_CYC     = (RELOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          STEP_HOLD_CYC  = 2;
    // register offsets
    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_STEP       = 8'h04;
    localparam logic [7:0]  OFF_SET        = 8'h08;
    localparam logic [7:0]  OFF_STATUS     = 8'h0C;
    localparam logic [7:0]  OFF_IRQ_STAT   = 8'h10;
    localparam logic [7:0]  OFF_IRQ_MASK   = 8'h14;
    // field positions
    localparam int          CTRL_REF_BIT   = 0;
    localparam int          CTRL_SEL_LSB   = 1;
    localparam int          CTRL_DIR_BIT   = 3;
    localparam int          CTRL_W         = 4;
    localparam logic [3:0]  CTRL_INIT      = 4'h0;
    localparam int          STEP_GO_BIT    = 0;
    localparam int          SET_DAT_LSB    = 0;
    localparam int          SET_ADR_LSB    = 8;
    localparam int          SET_WE_BIT     = 16;
    localparam int          SET_BUSY_BIT   = 31;
    localparam int          STAT_LOCK_BIT  = 0;
    localparam int          STAT_STBL_BIT  = 1;
    localparam int          STAT_WB_BIT    = 2;
    localparam int          STAT_STEP_BIT  = 3;
    localparam int          IRQ_W          = 4;
    localparam int          IRQ_STEP_BIT   = 0;
    localparam int          IRQ_SET_BIT    = 1;
    localparam int          IRQ_LOST_BIT   = 2;
    localparam int          IRQ_STBL_BIT   = 3;
    localparam logic [3:0]  IRQ_INIT       = 4'h0;
    // bus answers
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_TOGGLE, ST_HOLD} pdr_step_state_type;
endpackage : pdr_pkg

// >>> pdr_link_if.sv
// link between user control logic and the loop's control ports
interface pdr_link_if;
    logic [pdr_pkg::SEL_W-1:0] phase_output_select;
    logic                      phase_step_direction;
    logic                      phase_step_pulse;
    logic                      reference_clock_switch;
    logic                      wb_cyc;
    logic                      wb_stb;
    logic                      wb_we;
    logic [pdr_pkg::WB_AW-1:0] wb_adr;
    logic [pdr_pkg::WB_DW-1:0] wb_dat_w;
    logic [pdr_pkg::WB_DW-1:0] wb_dat_r;
    logic                      wb_ack;
    logic                      lock;

    modport user_end (
        output phase_output_select, phase_step_direction, phase_step_pulse, reference_clock_switch,
        output wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w,
        input  wb_dat_r, wb_ack, lock
    );
    modport pll_end (
        input  phase_output_select, phase_step_direction, phase_step_pulse, reference_clock_switch,
        input  wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w,
        output wb_dat_r, wb_ack, lock
    );
endinterface : pdr_link_if

// >>> pdr_relock.sv
// relock wait timer: busy for a fixed number of cycles after each start
module pdr_relock #(
    parameter int CYC = pdr_pkg::RELOCK_CYC
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // control
    input  wire logic i_start,
    output logic      o_busy
);
    localparam int CW = $clog2(CYC + 1);

    logic [CW-1:0] cnt_q;

    if (CYC < 1) begin : g_bad_cyc
        $error("pdr_relock: CYC must be at least 1");
    end

    // restart on every start, count down to zero; starts busy out of reset
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= CW'(CYC);
        end else if (i_start) begin
            cnt_q <= CW'(CYC);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
        end
    end

    assign o_busy = (cnt_q != '0);
endmodule : pdr_relock

// >>> pdr_pll_end.sv
// loop control end: phase stepping, reference select, settings bus port, lock indication
module pdr_pll_end #(
    parameter int         RELOCK_CYC = pdr_pkg::RELOCK_CYC,
    parameter logic [3:0] DYN_MASK   = pdr_pkg::DYN_MASK,
    parameter logic [1:0] FB_OUTPUT  = pdr_pkg::FB_OUTPUT
) (
    // clock and reset
    input  wire logic                                        I_CLK,
    input  wire logic                                        I_RST,
    // link to user logic
    pdr_link_if.pll_end                                      LINK,
    // loop state seen by the rest of the chip
    output logic                                             O_REF_SEL,
    output logic [pdr_pkg::NUM_OUT*pdr_pkg::PHASE_W-1:0]     O_PHASE,
    output logic [pdr_pkg::NUM_SET*pdr_pkg::WB_DW-1:0]       O_SETTINGS,
    output logic                                             O_LOCK
);
    localparam int PW = pdr_pkg::PHASE_W;

    logic          pulse_last_q;
    logic          step_seen;
    logic          step_ok;
    logic [PW-1:0] phase_q [pdr_pkg::NUM_OUT];
    logic          ref_sel_q;
    logic          ack_q;
    logic [7:0]    rdat_q;
    logic [7:0]    set_q [pdr_pkg::NUM_SET];
    logic          wb_hit;
    logic          set_hit;
    logic          relock_start;
    logic          relock_busy;
    logic          lock_q;

    // one step per toggle of the step input, either edge
    assign step_seen = LINK.phase_step_pulse ^ pulse_last_q;
    assign step_ok   = step_seen && DYN_MASK[LINK.phase_output_select];

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            pulse_last_q <= 1'b0;
        end else begin
            pulse_last_q <= LINK.phase_step_pulse;
        end
    end

    // phase of each output: fixed at its start value unless stepping is enabled for it
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            for (int i = 0; i < pdr_pkg::NUM_OUT; i++) begin
                phase_q[i] <= pdr_pkg::PHASE_INIT;
            end
        end else if (step_ok) begin
            if (LINK.phase_step_direction) begin
                phase_q[LINK.phase_output_select] <= phase_q[LINK.phase_output_select] + PW'(1);
            end else begin
                phase_q[LINK.phase_output_select] <= phase_q[LINK.phase_output_select] - PW'(1);
            end
        end
    end

    for (genvar g = 0; g < pdr_pkg::NUM_OUT; g++) begin : g_phase
        assign O_PHASE[g*PW +: PW] = phase_q[g];
    end

    // reference source select follows the user's switch
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ref_sel_q <= 1'b0;
        end else begin
            ref_sel_q <= LINK.reference_clock_switch;
        end
    end
    assign O_REF_SEL = ref_sel_q;

    // settings bus port: single-cycle acknowledge, unmapped reads as zero
    assign wb_hit  = LINK.wb_cyc && LINK.wb_stb && !ack_q;
    assign set_hit = (LINK.wb_adr < pdr_pkg::WB_AW'(pdr_pkg::NUM_SET));

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ack_q  <= 1'b0;
            rdat_q <= 8'h00;
        end else begin
            ack_q  <= wb_hit;
            rdat_q <= (wb_hit && set_hit) ? set_q[LINK.wb_adr[1:0]] : 8'h00;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            for (int i = 0; i < pdr_pkg::NUM_SET; i++) begin
                set_q[i] <= pdr_pkg::SET_INIT;
            end
        end else if (wb_hit && LINK.wb_we && set_hit) begin
            set_q[LINK.wb_adr[1:0]] <= LINK.wb_dat_w;
        end
    end

    for (genvar g = 0; g < pdr_pkg::NUM_SET; g++) begin : g_set
        assign O_SETTINGS[g*8 +: 8] = set_q[g];
    end
    assign LINK.wb_ack   = ack_q;
    assign LINK.wb_dat_r = rdat_q;

    // anything that disturbs the loop restarts the relock wait
    assign relock_start = (step_ok && LINK.phase_output_select == FB_OUTPUT)
                        || (wb_hit && LINK.wb_we && set_hit)
                        || (ref_sel_q != LINK.reference_clock_switch);

    pdr_relock #(.CYC(RELOCK_CYC)) pdr_relock_inst (
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_start (relock_start),
        .o_busy  (relock_busy)
    );

    // lock is low from the cycle after the disturbing one until the wait has run out
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= !relock_start && !relock_busy;
        end
    end
    assign O_LOCK    = lock_q;
    assign LINK.lock = lock_q;
endmodule : pdr_pll_end

// >>> pdr_link_monitor.sv
// assertions on the link between user control logic and the loop
module pdr_link_monitor #(
    parameter int RELOCK_CYC = pdr_pkg::RELOCK_CYC
) (
    // clock and reset
    input wire logic       I_CLK,
    input wire logic       I_RST,
    // link signals
    input wire logic [1:0] phase_output_select,
    input wire logic       phase_step_direction,
    input wire logic       phase_step_pulse,
    input wire logic       reference_clock_switch,
    input wire logic       wb_cyc,
    input wire logic       wb_stb,
    input wire logic       wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic       wb_ack,
    input wire logic       lock
);
    timeunit 1ns;
    timeprecision 1ps;
    int low_q;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    // counts cycles spent without lock
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST)
            low_q <= 0;
        else
            low_q <= lock ? 0 : low_q + 1;
    end
    sel_held_a: assert property ($changed(phase_step_pulse) |-> $stable(phase_output_select)
        ##1 $stable(phase_output_select)[*2]) else $error("select moved around a step");
    dir_held_a: assert property ($changed(phase_step_pulse) |-> $stable(phase_step_direction)
        ##1 $stable(phase_step_direction)[*2]) else $error("direction moved around a step");
    ack_pulse_a: assert property (wb_ack |=> !wb_ack) else $error("ack longer than one cycle");
    ack_timing_a: assert property ($rose(wb_cyc) |-> wb_stb && !wb_ack ##1 wb_ack) else $error("ack late");
    cyc_release_a: assert property (wb_ack |-> wb_cyc && wb_stb ##1 !wb_cyc) else $error("cycle kept");
    fb_step_lock_a: assert property ($changed(phase_step_pulse) && phase_output_select == pdr_pkg::FB_OUTPUT
        |=> !lock) else $error("lock kept after feedback step");
    wb_lock_a: assert property (wb_ack && wb_we && wb_adr < 8'h04 |-> ##[0:2] !lock) else $error("lock kept");
    ref_lock_a: assert property ($changed(reference_clock_switch) |-> ##[1:2] !lock) else $error("no relock");
    relock_time_a: assert property ($rose(lock) |-> low_q >= RELOCK_CYC) else $error("relock too soon");
    // main scenarios
    cover property ($changed(phase_step_pulse) && !phase_step_direction);
    cover property (wb_ack && !wb_we);
    cover property ($rose(lock));
endmodule : pdr_link_monitor

// >>> tb_top.sv
// self-checking bench for both ends of the loop control link
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RLK = 5;
    logic        clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wda = 32'h0, q, rd, sets;
    logic [1:0]  r, bs, rs;
    logic        awr, wrd, arr, bv, rv, irq, ref_sel, lk;
    logic [11:0] phase;
    int          failures = 0, n_checks = 0, cyc = 0;
    pdr_link_if link ();
    pdr_user_end #(.RELOCK_CYC(RLK)) pdr_user_end_inst (.I_CLK(clk), .I_RST(rst), .I_AWADDR(awa),
        .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wda), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wrd),
        .O_BRESP(bs), .O_BVALID(bv), .I_BREADY(br), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr),
        .O_RDATA(rd), .O_RRESP(rs), .O_RVALID(rv), .I_RREADY(rr), .O_IRQ(irq), .LINK(link));
    pdr_pll_end #(.RELOCK_CYC(RLK)) pdr_pll_end_inst (.I_CLK(clk), .I_RST(rst), .LINK(link),
        .O_REF_SEL(ref_sel), .O_PHASE(phase), .O_SETTINGS(sets), .O_LOCK(lk));
    pdr_link_monitor #(.RELOCK_CYC(RLK)) pdr_link_monitor_inst (.I_CLK(clk), .I_RST(rst),
        .phase_output_select(link.phase_output_select), .phase_step_direction(link.phase_step_direction),
        .phase_step_pulse(link.phase_step_pulse), .reference_clock_switch(link.reference_clock_switch),
        .wb_cyc(link.wb_cyc), .wb_stb(link.wb_stb), .wb_we(link.wb_we), .wb_adr(link.wb_adr),
        .wb_ack(link.wb_ack), .lock(link.lock));
    // clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end
    // one register access; bready or rready held until the answer
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        if (w) begin
            awa <= a; wda <= d; awv <= 1'h1; wv <= 1'h1; br <= 1'h1;
        end else begin
            ara <= a; arv <= 1'h1; rr <= 1'h1;
        end
        do begin
            @(posedge clk);
            if (awr) awv <= 1'h0;
            if (wrd) wv <= 1'h0;
            if (arr) arv <= 1'h0;
        end while (!(w ? bv : rv));
        q = rd;
        r = w ? bs : rs;
        br <= 1'h0;
        rr <= 1'h0;
        @(posedge clk);
    endtask : acc
    // polls status until locked, stable and idle
    task automatic wait_idle();
        do acc(1'h0, 8'h0C, 32'h0); while (q[3:0] !== 4'h3);
    endtask : wait_idle
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        wait_idle();
        for (int i = 0; i < 4; i++) begin
            acc(1'h1, 8'h00, 32'(8 + 2 * i));
            acc(1'h1, 8'h04, 32'h1);
            wait_idle();
            chk(phase[3*i+:3], 3'h1);
        end
        acc(1'h1, 8'h00, 32'h6);
        repeat (2) begin acc(1'h1, 8'h04, 32'h1); wait_idle(); end
        chk(phase[11:9], 3'h7);
        acc(1'h0, 8'h10, 32'h0);
        chk(q[0], 1'h1);
        chk(irq, 1'h0);
        acc(1'h1, 8'h14, 32'h1);
        chk(irq, 1'h1);
        acc(1'h1, 8'h10, 32'hF);
        chk(irq, 1'h0);
        acc(1'h1, 8'h08, 32'h1025A);
        wait_idle();
        chk(sets[23:16], 8'h5A);
        acc(1'h1, 8'h08, 32'h200);
        wait_idle();
        acc(1'h0, 8'h08, 32'h0);
        chk(q[7:0], 8'h5A);
        acc(1'h1, 8'h00, 32'h1);
        wait_idle();
        chk(ref_sel, 1'h1);
        chk(lk, 1'h1);
        acc(1'h1, 8'h20, 32'h5);
        chk(r, 2'h2);
        acc(1'h0, 8'h20, 32'h0);
        chk(r, 2'h2);
        end_of_test();
    end
endmodule : tb_top
